// [src/crc_top.sv]
`default_nettype none
// supply controller: regulator choice, voltage scaling, brown-out config
module crc_top (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // power manager side
    input wire logic standby_req,
    input wire logic walk_req,
    // start-up configuration row
    input wire logic cfg_load,
    input wire logic cfg_bo_enable,
    input wire logic cfg_bo_hysteresis_enable,
    // analogue side
    input wire logic brownout_det,
    output logic reg_buck_sel,
    output logic [7:0] core_level,
    output logic bo_enable,
    output logic bo_hysteresis_enable,
    // interrupt
    output logic irq
);
    // control register
    logic regulator_select;
    logic perf_high;
    logic sw_standby;
    logic sw_walk;
    // status / mask
    logic [2:0] status;
    logic [2:0] mask;
    // brown-out action field
    logic [1:0] bo_action;
    // level table
    logic [7:0] lvl_low;
    logic [7:0] lvl_high;
    logic [7:0] lvl_stby;
    crc_pkg::crc_scale_t scale;
    // bus data phase capture
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    // submodule outputs
    logic regulator_ready_flag;
    logic act_sel;
    logic ready_q;
    logic [7:0] level;
    logic scaled;
    logic [7:0] target;
    logic in_stby;
    logic [31:0] rd_mux;
    logic [7:0] acc;
    logic ready_rise;
    logic bo_event;
    // regulator swap sequencer
    crc_switch u_switch (
        .hclk(hclk),
        .hresetn(hresetn),
        .sel(regulator_select),
        .ready(regulator_ready_flag),
        .active_sel(act_sel)
    );
    // voltage stepping engine
    crc_scaler u_scaler (
        .hclk(hclk),
        .hresetn(hresetn),
        .cfg(scale),
        .target(target),
        .level(level),
        .done_pulse(scaled)
    );
    // target from performance level or sleep state
    always_comb
    begin
        // a sleepwalk task during standby runs at the active level
        in_stby = standby_req || sw_standby;
        if (in_stby && !(walk_req || sw_walk))
            target = lvl_stby;
        else if (perf_high)
            target = lvl_high;
        else
            target = lvl_low;
    end
    // address phase capture
    // held through a wait state so the data phase keeps its address
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end
        else if (hready)
        begin
            dp_valid <= hsel && htrans[1];
            dp_write <= hwrite;
            dp_addr <= haddr[7:0];
        end
    end
    // event sources
    always_comb
    begin
        ready_rise = regulator_ready_flag && !ready_q;
        bo_event = brownout_det && bo_enable
            && bo_action == crc_pkg::CRC_BO_ACT_INT;
        acc = dp_valid ? dp_addr : 8'hff;
    end
    // ready edge history
    // resets to the flag's own reset level, so no false edge after reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ready_q <= 1'b1;
        else
            ready_q <= regulator_ready_flag;
    end
    // control register writes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            regulator_select <= 1'b0;
            perf_high <= 1'b0;
            sw_standby <= 1'b0;
            sw_walk <= 1'b0;
            mask <= 3'h0;
            lvl_low <= crc_pkg::CRC_LVL_LOW_RST;
            lvl_high <= crc_pkg::CRC_LVL_HIGH_RST;
            lvl_stby <= crc_pkg::CRC_LVL_STBY_RST;
            scale <= '{period: crc_pkg::CRC_PER_RST,
                step: crc_pkg::CRC_STEP_RST};
        end
        else if (dp_write && acc == crc_pkg::CRC_OFF_CTRL)
        begin
            regulator_select <= hwdata[crc_pkg::CRC_CTRL_SEL];
            perf_high <= hwdata[crc_pkg::CRC_CTRL_PERF];
            sw_standby <= hwdata[crc_pkg::CRC_CTRL_STBY];
            sw_walk <= hwdata[crc_pkg::CRC_CTRL_WALK];
        end
        else if (dp_write && acc == crc_pkg::CRC_OFF_MASK)
            mask <= hwdata[2:0];
        else if (dp_write && acc == crc_pkg::CRC_OFF_LEVEL)
        begin
            lvl_low <= hwdata[7:0];
            lvl_high <= hwdata[15:8];
            lvl_stby <= hwdata[23:16];
        end
        else if (dp_write && acc == crc_pkg::CRC_OFF_SCALE)
        begin
            scale.step <= hwdata[crc_pkg::CRC_SC_STEP_LSB +: 4];
            scale.period <= hwdata[crc_pkg::CRC_SC_PER_LSB +: 4];
        end
    end
    // brown-out settings: enable and hysteresis loaded at start-up, all writable except in a cycle with cfg_load high
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bo_enable <= 1'b0;
            bo_hysteresis_enable <= 1'b0;
            bo_action <= 2'h0;
        end
        else if (cfg_load)
        begin
            // strap values taken after release, never under reset
            bo_enable <= cfg_bo_enable;
            bo_hysteresis_enable <= cfg_bo_hysteresis_enable;
        end
        else if (dp_write && acc == crc_pkg::CRC_OFF_BROWN)
        begin
            bo_enable <= hwdata[crc_pkg::CRC_BO_ENABLE];
            bo_hysteresis_enable <= hwdata[crc_pkg::CRC_BO_HYSTERESIS_ENABLE];
            // reserved code is refused, old action kept
            if (hwdata[crc_pkg::CRC_BO_ACT_LSB +: 2]
                != crc_pkg::CRC_BO_ACT_RSVD)
                bo_action <= hwdata[crc_pkg::CRC_BO_ACT_LSB +: 2];
        end
    end
    // sticky status: set wins over the read clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            status <= 3'h0;
        else
        begin
            // cleared in the read's wait state only, so once per read
            if (!hreadyout && acc == crc_pkg::CRC_OFF_STATUS)
                status <= {scaled, bo_event, ready_rise};
            else
                status <= status | {scaled, bo_event, ready_rise};
        end
    end
    // read mux
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (acc)
            crc_pkg::CRC_OFF_CTRL: rd_mux = {28'h0, sw_walk, sw_standby,
                perf_high, regulator_select};
            crc_pkg::CRC_OFF_STATUS: rd_mux = {20'h0, level, 1'b0,
                status};
            crc_pkg::CRC_OFF_MASK: rd_mux = {29'h0, mask};
            crc_pkg::CRC_OFF_BROWN: rd_mux = {27'h0, bo_action, bo_hysteresis_enable,
                bo_enable, regulator_ready_flag};
            crc_pkg::CRC_OFF_LEVEL: rd_mux = {8'h00, lvl_stby, lvl_high,
                lvl_low};
            crc_pkg::CRC_OFF_SCALE: rd_mux = {20'h0, scale.period, 4'h0,
                scale.step};
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    // registered outputs; a read takes one wait state, a write none
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
            irq <= 1'b0;
            reg_buck_sel <= 1'b0;
            core_level <= crc_pkg::CRC_LVL_LOW_RST;
        end
        else
        begin
            // the wait state lets read data come straight from a flop
            if (hready && hsel && htrans[1] && !hwrite)
                hreadyout <= 1'b0;
            else
                hreadyout <= 1'b1;
            // read data loaded at the end of the wait state
            if (!hreadyout)
                hrdata <= rd_mux;
            irq <= |(status & mask);
            reg_buck_sel <= act_sel;
            core_level <= level;
        end
    end
    // a select change drops ready on the next edge
    AST_SEL_CLEARS_READY: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $changed(regulator_select) |=> !regulator_ready_flag)
        else $error("ready not cleared on select change");
    // a rising ready flag is latched as a status bit
    AST_RISE_SETS_STATUS: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ready_rise |=> status[crc_pkg::CRC_ST_READY])
        else $error("ready edge not latched");
    // an unmasked pending bit raises the line
    AST_IRQ_FOLLOWS: assert property (
        @(posedge hclk) disable iff (!hresetn)
        |(status & mask) |=> irq)
        else $error("interrupt not raised");
    // the line falls once nothing unmasked is pending
    AST_IRQ_DROPS: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !(|(status & mask)) |=> !irq)
        else $error("interrupt stuck high");
    // the reserved action code is never stored
    AST_RSVD_ACTION: assert property (
        @(posedge hclk) disable iff (!hresetn)
        bo_action != crc_pkg::CRC_BO_ACT_RSVD)
        else $error("reserved action stored");
    // a detection with the interrupt action is latched
    AST_BO_LATCH: assert property (
        @(posedge hclk) disable iff (!hresetn)
        bo_event |=> status[crc_pkg::CRC_ST_BROWN])
        else $error("brown-out event not latched");
    // the start-up row lands in the settings on the next edge
    AST_CFG_LOAD: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cfg_load |=> bo_enable == $past(cfg_bo_enable)
        && bo_hysteresis_enable == $past(cfg_bo_hysteresis_enable))
        else $error("config row not loaded");
    // software can switch the monitor on in any cycle without cfg_load
    AST_BO_WRITE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (dp_write && acc == crc_pkg::CRC_OFF_BROWN && !cfg_load
        && hwdata[crc_pkg::CRC_BO_ENABLE]) |=> bo_enable)
        else $error("enable bit not writable");
    // active high level outside standby
    AST_TARGET: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (!in_stby && perf_high) |-> target == lvl_high)
        else $error("wrong target level");
    // standby without a sleepwalk task selects the standby level
    AST_STBY_TARGET: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (in_stby && !walk_req && !sw_walk) |-> target == lvl_stby)
        else $error("standby level not selected");
endmodule : crc_top
`default_nettype wire

// [src/crc_pkg.sv]
// Summary of operation
// - reset powers core supply from low-dropout regulator
// - software switches regulator type on the fly
// - select change clears the ready flag
// - ready flag sets when switching completes
// - ready interrupt on flag zero-to-one edge
// - voltage moves on level, standby, sleepwalk changes
// - step size applied once per programmed period
// - maximum step size finishes in one step
// - target level from performance level or sleep
// - brown-out action 0x2 interrupts, 0x3 reserved
// - hysteresis bit 2, loaded at start-up
// - enable bit 1, loaded at start-up, writable
`default_nettype none
package crc_pkg;
    // register byte offsets
    localparam logic [7:0] CRC_OFF_CTRL = 8'h00;
    localparam logic [7:0] CRC_OFF_STATUS = 8'h04;
    localparam logic [7:0] CRC_OFF_MASK = 8'h08;
    localparam logic [7:0] CRC_OFF_BROWN = 8'h0c;
    localparam logic [7:0] CRC_OFF_LEVEL = 8'h10;
    localparam logic [7:0] CRC_OFF_SCALE = 8'h14;
    // control register fields
    localparam int CRC_CTRL_SEL = 0;
    localparam int CRC_CTRL_PERF = 1;
    localparam int CRC_CTRL_STBY = 2;
    localparam int CRC_CTRL_WALK = 3;
    // status / mask bit positions
    localparam int CRC_ST_READY = 0;
    localparam int CRC_ST_BROWN = 1;
    localparam int CRC_ST_SCALED = 2;
    // brown-out config fields
    localparam int CRC_BO_ENABLE = 1;
    localparam int CRC_BO_HYSTERESIS_ENABLE = 2;
    localparam int CRC_BO_ACT_LSB = 3;
    localparam logic [1:0] CRC_BO_ACT_INT = 2'h2;
    localparam logic [1:0] CRC_BO_ACT_RSVD = 2'h3;
    // scaling fields
    localparam int CRC_SC_STEP_LSB = 0;
    localparam int CRC_SC_PER_LSB = 8;
    localparam logic [3:0] CRC_STEP_MAX = 4'hf;
    // reset values
    localparam logic [3:0] CRC_STEP_RST = 4'h1;
    localparam logic [3:0] CRC_PER_RST = 4'h2;
    // level codes (arbitrary millivolt-like units)
    localparam logic [7:0] CRC_LVL_LOW_RST = 8'h40;
    localparam logic [7:0] CRC_LVL_HIGH_RST = 8'h60;
    localparam logic [7:0] CRC_LVL_STBY_RST = 8'h30;
    // regulator switch time and cycle count at 125 MHz
    localparam int CRC_CLK_MHZ = 125;
    localparam int CRC_SWITCH_NS = 200;
    localparam int CRC_SWITCH_CYC = (CRC_SWITCH_NS * CRC_CLK_MHZ + 999) / 1000;
    // base tick of the scaling period, in cycles
    localparam int CRC_TICK_CYC = 8;
    // packed scaling configuration
    typedef struct packed {
        logic [3:0] period;
        logic [3:0] step;
    } crc_scale_t;
endpackage : crc_pkg
`default_nettype wire

// [src/crc_switch.sv]
`default_nettype none
// runs the regulator swap: ready drops on a select change, rises after
module crc_switch (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic sel,
    // status
    output logic ready,
    output logic active_sel
);
    logic [7:0] cnt; // settle counter
    logic busy; // swap in progress
    // swap sequencer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ready <= 1'b1;
            busy <= 1'b0;
            cnt <= 8'h00;
            active_sel <= 1'b0; // low-dropout after reset
        end
        else if (!busy && sel != active_sel)
        begin
            // a request while idle starts the sequence; one during a swap waits for it to end
            busy <= 1'b1;
            ready <= 1'b0;
            cnt <= 8'(crc_pkg::CRC_SWITCH_CYC);
            active_sel <= sel;
        end
        else if (busy)
        begin
            if (cnt == 8'h01)
            begin
                busy <= 1'b0;
                ready <= 1'b1;
            end
            cnt <= cnt - 8'h01;
        end
    end
    // last low sample of ready, counted from the first low one
    localparam int SETTLE_LAST = crc_pkg::CRC_SWITCH_CYC - 1;
    // ready is low at the first and the last sample of the settle time, then comes back
    sequence settle_s;
        !ready ##SETTLE_LAST !ready ##1 ready;
    endsequence
    // ready must return exactly after the settle time
    AST_READY_BACK: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $fell(ready) |-> settle_s)
        else $error("ready did not return on time");
    // low-dropout is the regulator in use right after reset
    AST_RST_LDO: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> !active_sel)
        else $error("not on low-dropout after reset");
endmodule : crc_switch
`default_nettype wire

// [src/crc_scaler.sv]
`default_nettype none
// steps the core level toward a target, one step per period
module crc_scaler (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // configuration
    input wire crc_pkg::crc_scale_t cfg,
    input wire logic [7:0] target,
    // state
    output logic [7:0] level,
    output logic done_pulse
);
    logic [11:0] tick; // period counter
    logic [7:0] diff; // remaining distance
    logic up; // direction
    logic [7:0] stepv; // step size of this move
    logic [11:0] tick_last; // last count of one period
    always_comb
    begin
        up = target > level;
        diff = up ? target - level : level - target;
        stepv = {4'h0, cfg.step};
        // (period + 1) base ticks, so a zero period is still one tick
        tick_last = ({8'h00, cfg.period} + 12'h001)
            * 12'(crc_pkg::CRC_TICK_CYC) - 12'h001;
    end
    // stepping process
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            level <= crc_pkg::CRC_LVL_LOW_RST;
            tick <= 12'h000;
            done_pulse <= 1'b0;
        end
        else
        begin
            done_pulse <= 1'b0;
            if (level == target)
                tick <= 12'h000;
            else if (cfg.step == crc_pkg::CRC_STEP_MAX)
            begin
                level <= target; // single jump
                done_pulse <= 1'b1;
            end
            else if (tick >= tick_last)
            begin
                // one increment per period, clipped at target
                tick <= 12'h000;
                if (diff <= stepv || stepv == 8'h00)
                begin
                    level <= target;
                    done_pulse <= 1'b1;
                end
                else
                    level <= up ? level + stepv : level - stepv;
            end
            else
                tick <= tick + 12'h001;
        end
    end
    // the largest step size lands on the target in one edge
    AST_ONE_STEP: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (cfg.step == crc_pkg::CRC_STEP_MAX && level != target)
        |=> level == $past(target))
        else $error("max step did not jump");
endmodule : crc_scaler
`default_nettype wire

// [dv/crc_analog_model.sv]
`default_nettype none
// analogue brown-out detector seen from the control logic
module crc_analog_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // settings from the controller
    input wire logic bo_enable,
    input wire logic bo_hysteresis_enable,
    // bench command: supply dips below threshold
    input wire logic trip,
    // detector output
    output logic brownout_det
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] hold; // hysteresis keeps the flag a few cycles longer

    // hold counter restarts while the supply is low
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hold <= 3'h0;
        else if (trip)
            hold <= 3'h4;
        else if (hold != 3'h0)
            hold <= hold - 3'h1;
    end

    // a disabled monitor never reports, whatever the supply does
    assign brownout_det = bo_enable
        & (trip | (bo_hysteresis_enable & (hold != 3'h0)));
endmodule : crc_analog_model
`default_nettype wire

// [dv/core_regulator_control_test.sv]
`default_nettype none
module core_regulator_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    // short names for the register offsets
    localparam logic [7:0] A_CTRL = crc_pkg::CRC_OFF_CTRL;
    localparam logic [7:0] A_ST = crc_pkg::CRC_OFF_STATUS;
    localparam logic [7:0] A_MASK = crc_pkg::CRC_OFF_MASK;
    localparam logic [7:0] A_BO = crc_pkg::CRC_OFF_BROWN;
    localparam logic [7:0] A_SC = crc_pkg::CRC_OFF_SCALE;
    // bus side
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, irq;
    // power manager, start-up row and analogue side
    logic standby_req = 1'b0;
    logic walk_req = 1'b0;
    logic cfg_load = 1'b0;
    logic cfg_bo_enable = 1'b0;
    logic cfg_bo_hysteresis_enable = 1'b0;
    logic trip = 1'b0;
    logic brownout_det, reg_buck_sel, bo_enable, bo_hysteresis_enable;
    logic [7:0] core_level;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;

    crc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .standby_req(standby_req),
        .walk_req(walk_req), .cfg_load(cfg_load),
        .cfg_bo_enable(cfg_bo_enable), .cfg_bo_hysteresis_enable(cfg_bo_hysteresis_enable),
        .brownout_det(brownout_det), .reg_buck_sel(reg_buck_sel),
        .core_level(core_level), .bo_enable(bo_enable),
        .bo_hysteresis_enable(bo_hysteresis_enable), .irq(irq));
    crc_analog_model ana (.hclk(hclk), .hresetn(hresetn),
        .bo_enable(bo_enable), .bo_hysteresis_enable(bo_hysteresis_enable), .trip(trip),
        .brownout_det(brownout_det));

    // 125 MHz clock
    always #4 hclk = ~hclk;

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            test_done();
        end
    end

    task automatic test_done();
        if (errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // one single transfer; waits on hready in both phases
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask : rd

    // bounded wait for the interrupt line
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 100)
        begin
            @(posedge hclk);
            n++;
        end
    endtask : wait_irq

    // swap to buck and back, watching ready flag and interrupt
    task automatic t_switch();
        logic [31:0] q;
        wr(A_MASK, 32'h1);
        for (int s = 1; s >= 0; s--)
        begin
            wr(A_CTRL, 32'(s));
            rd(A_BO, q);
            check(q[0], 1'b0);
            wait_irq();
            check(irq, 1'b1);
            check(reg_buck_sel, s[0]);
            rd(A_BO, q);
            check(q[0], 1'b1);
            rd(A_ST, q);
            check(q[0], 1'b1);
            rd(A_ST, q);
            check(q[0], 1'b0);
            check(irq, 1'b0);
        end
    endtask : t_switch

    // move the level and judge every step size and spacing
    task automatic t_scale(input logic [3:0] st, input logic [3:0] pe,
        input logic sb, input logic [7:0] tgt);
        logic [7:0] prev;
        int diff, rem, gap, jumps;
        wr(A_SC, {20'h0, pe, 4'h0, st});
        prev = core_level;
        diff = tgt > prev ? tgt - prev : prev - tgt;
        gap = 0;
        jumps = 0;
        standby_req <= sb;
        wr(A_CTRL, 32'h2);
        for (int n = 0; n < 2000 && prev !== tgt; n++)
        begin
            @(posedge hclk);
            gap++;
            if (core_level !== prev)
            begin
                rem = tgt > prev ? tgt - prev : prev - tgt;
                check(core_level > prev ? core_level - prev
                    : prev - core_level, (st == crc_pkg::CRC_STEP_MAX
                    || rem < st) ? rem : st);
                if (jumps > 0)
                    check(gap, (pe + 1) * crc_pkg::CRC_TICK_CYC);
                gap = 0;
                jumps++;
                prev = core_level;
            end
        end
        check(core_level, tgt);
        check(jumps, st == crc_pkg::CRC_STEP_MAX ? 1
            : (diff + st - 1) / st);
    endtask : t_scale

    // standby and sleepwalk from the pins and from the control bits
    task automatic t_walk();
        logic [31:0] q;
        standby_req <= 1'b1;
        repeat (4) @(posedge hclk);
        check(core_level, crc_pkg::CRC_LVL_STBY_RST);
        walk_req <= 1'b1;
        repeat (4) @(posedge hclk);
        check(core_level, crc_pkg::CRC_LVL_HIGH_RST);
        walk_req <= 1'b0;
        standby_req <= 1'b0;
        wr(A_CTRL, 32'h6);
        repeat (4) @(posedge hclk);
        check(core_level, crc_pkg::CRC_LVL_STBY_RST);
        wr(A_CTRL, 32'he);
        repeat (4) @(posedge hclk);
        check(core_level, crc_pkg::CRC_LVL_HIGH_RST);
        wr(A_CTRL, 32'h0);
        repeat (4) @(posedge hclk);
        check(core_level, crc_pkg::CRC_LVL_LOW_RST);
        rd(A_ST, q);
        check(q[11:4], crc_pkg::CRC_LVL_LOW_RST);
        check(q[2], 1'b1);
    endtask : t_walk

    // start-up load, action field, detection interrupt, writes
    task automatic t_brown();
        logic [31:0] q;
        cfg_bo_enable <= 1'b1;
        cfg_bo_hysteresis_enable <= 1'b1;
        cfg_load <= 1'b1;
        @(posedge hclk);
        cfg_load <= 1'b0;
        repeat (2) @(posedge hclk);
        check(bo_enable, 1'b1);
        check(bo_hysteresis_enable, 1'b1);
        wr(A_MASK, 32'h2);
        wr(A_BO, 32'h16);
        wr(A_BO, 32'h1e);
        rd(A_BO, q);
        check(q[4:3], crc_pkg::CRC_BO_ACT_INT);
        trip <= 1'b1;
        @(posedge hclk);
        trip <= 1'b0;
        wait_irq();
        check(irq, 1'b1);
        rd(A_ST, q);
        check(q[1], 1'b1);
        wr(A_BO, 32'h14);
        @(posedge hclk);
        check(bo_enable, 1'b0);
        wr(A_BO, 32'h10);
        @(posedge hclk);
        check(bo_hysteresis_enable, 1'b0);
        rd(A_ST, q);
        trip <= 1'b1;
        @(posedge hclk);
        trip <= 1'b0;
        repeat (3) @(posedge hclk);
        rd(A_ST, q);
        check(q[1], 1'b0);
    endtask : t_brown

    // main sequence
    initial
    begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check(reg_buck_sel, 1'b0);
        check(core_level, crc_pkg::CRC_LVL_LOW_RST);
        check(irq, 1'b0);
        t_switch();
        t_scale(4'h1, 4'h0, 1'b0, crc_pkg::CRC_LVL_HIGH_RST);
        t_scale(4'h5, 4'h1, 1'b1, crc_pkg::CRC_LVL_STBY_RST);
        t_scale(crc_pkg::CRC_STEP_MAX, 4'h0, 1'b0,
            crc_pkg::CRC_LVL_HIGH_RST);
        t_walk();
        t_brown();
        test_done();
    end
endmodule : core_regulator_control_test
`default_nettype wire
